// ===== include/pmb_defs.vh
// Constants for the parallel master bus sequencer.
// Assumes inclusion by bare name from design files.
`ifndef PMB_DEFS_VH
`define PMB_DEFS_VH
// ----------------------------------------
// Mode and field encodings
// ----------------------------------------
`define PMB_MODE_SPLIT 2'b10
`define PMB_MODE_ENABLE 2'b11
`define PMB_STEP_NONE 2'b00
`define PMB_STEP_UP 2'b01
`define PMB_STEP_DOWN 2'b10
`define PMB_MUX_NONE 2'b00
`define PMB_MUX_PART 2'b01
`define PMB_MUX_FULL 2'b10
`define PMB_CSF_ADDR 2'b00
`define PMB_CSF_CS2 2'b01
`define PMB_CSF_BOTH 2'b10
// ----------------------------------------
// Wait field positions
// ----------------------------------------
`define PMB_WB_HI 7
`define PMB_WB_LO 6
`define PMB_WM_HI 5
`define PMB_WM_LO 2
`define PMB_WE_HI 1
`define PMB_WE_LO 0
// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define PMB_ADDR_RST 16'h0000
`define PMB_DATA_RST 8'h00
`define PMB_FIFO_DEPTH 16
`endif

// ===== hw/pmb_fifo.v
// Write-data FIFO for queued bus writes.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module pmb_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] cnt_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data = mem[rd_reg];
  always @(posedge clk_sys) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_reg <= wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== hw/pmb_addr_step.v
// Next-address calculation with chip-select bits held out of stepping.
// Assumes purely combinational use by the sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "pmb_defs.vh"
module pmb_addr_step (
  // Current address and mode
  input wire [15:0] addr_in,
  input wire [1:0] addr_step_mode,
  input wire [1:0] cs_func,
  // Result
  output reg [15:0] addr_out
);
  reg [15:0] keep_mask;
  reg [15:0] stepped;
  always @* begin
    keep_mask = 16'h0000;
    stepped = addr_in;
    // ----------------------------------------
    // Chip-select bits excluded
    // ----------------------------------------
    if (cs_func == `PMB_CSF_CS2) begin
      keep_mask = 16'h8000;
    end else if (cs_func == `PMB_CSF_BOTH) begin
      keep_mask = 16'hc000;
    end
    if (addr_step_mode == `PMB_STEP_UP) begin
      stepped = addr_in + 16'h0001;
    end else if (addr_step_mode == `PMB_STEP_DOWN) begin
      stepped = addr_in - 16'h0001;
    end
    addr_out = (addr_in & keep_mask) | (stepped & ~keep_mask);
  end
endmodule
`default_nettype wire

// ===== hw/pmb_sequencer.v
// Master-mode transaction engine of a parallel port.
// Assumes software access strobes are single-cycle pulses on clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "pmb_defs.vh"
module pmb_sequencer #(
  parameter FIFO_DEPTH = `PMB_FIFO_DEPTH,
  parameter FIFO_AW = 4
) (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // Configuration
  input wire port_enable,
  input wire [1:0] port_mode,
  input wire wide_data_select,
  input wire [1:0] addr_step_mode,
  input wire [7:0] port_wait_reg,
  input wire [1:0] addr_mux_mode,
  input wire [1:0] cs_func,
  input wire cs1_active_high,
  input wire cs2_active_high,
  input wire irq_enable,
  // Address load
  input wire addr_load,
  input wire [15:0] addr_load_value,
  // Software data access
  input wire data_low_read,
  input wire data_low_write,
  input wire [7:0] data_low_wdata,
  input wire data_high_write,
  input wire [7:0] data_high_wdata,
  output wire write_ready,
  // Status
  output reg [7:0] xfer_data_low,
  output reg [7:0] xfer_data_high,
  output reg [15:0] addr_reg,
  output wire busy,
  output reg cycle_done_irq,
  // Parallel bus pins
  output reg [7:0] port_data_out,
  output reg port_data_oe,
  input wire [7:0] port_data_in,
  output reg [15:0] addr_pins,
  output reg read_strobe_out,
  output reg write_strobe_out,
  output reg enable_strobe_out,
  output reg byte_enable_strobe,
  output reg addr_latch_low_strobe,
  output reg addr_latch_high_strobe,
  output reg [1:0] chip_select_out
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ALL = 7'h02;
  localparam [6:0] ST_ALH = 7'h04;
  localparam [6:0] ST_SETUP = 7'h08;
  localparam [6:0] ST_STRB = 7'h10;
  localparam [6:0] ST_HOLD = 7'h20;
  localparam [6:0] ST_DONE = 7'h40;

  reg [6:0] state_reg;
  reg [6:0] state_next;
  reg [3:0] wcnt_reg;
  reg [3:0] wcnt_next;
  reg is_read_reg;
  reg second_reg;
  reg [7:0] wbyte_high_reg;
  reg [7:0] wbyte_low_reg;
  wire [15:0] addr_stepped;
  wire master_on = port_enable && port_mode[1];
  wire [1:0] wb = port_wait_reg[`PMB_WB_HI:`PMB_WB_LO];
  wire [3:0] wm = port_wait_reg[`PMB_WM_HI:`PMB_WM_LO];
  wire [1:0] we = port_wait_reg[`PMB_WE_HI:`PMB_WE_LO];
  wire waits_on = (wm != 4'h0);
  wire [15:0] fifo_in = {data_high_wdata, data_low_wdata};
  wire fifo_valid;
  wire [15:0] fifo_data;
  wire idle = (state_reg == ST_IDLE);
  wire start_rd = master_on && idle && data_low_read && !fifo_valid;
  wire take_wr = master_on && idle && fifo_valid && !start_rd;
  wire last_byte = !wide_data_select || second_reg;
  wire fifo_pop = take_wr;
  wire enable_mode = (port_mode == `PMB_MODE_ENABLE);

  // ----------------------------------------
  // Write queue
  // ----------------------------------------
  pmb_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(data_low_write && master_on),
    .in_ready(write_ready),
    .in_data(fifo_in),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  pmb_addr_step u_step (
    .addr_in(addr_reg),
    .addr_step_mode(addr_step_mode),
    .cs_func(cs_func),
    .addr_out(addr_stepped)
  );

  // Busy except on the final cycle of a transfer
  assign busy = !idle && !(state_reg == ST_DONE && last_byte);

  // ----------------------------------------
  // Phase entry helper
  // ----------------------------------------
  function [10:0] enter_after_addr;
    input [1:0] wbv;
    input [3:0] wmv;
    input won;
    begin
      if (won && wbv != 2'b00) begin
        enter_after_addr = {ST_SETUP, 2'b00, wbv};
      end else begin
        enter_after_addr = {ST_STRB, wmv};
      end
    end
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always @* begin
    state_next = state_reg;
    wcnt_next = wcnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_rd || take_wr) begin
          if (addr_mux_mode != `PMB_MUX_NONE) begin
            state_next = ST_ALL;
          end else begin
            {state_next, wcnt_next} = enter_after_addr(wb, wm, waits_on);
          end
        end
      end
      ST_ALL: begin
        if (addr_mux_mode == `PMB_MUX_FULL) begin
          state_next = ST_ALH;
        end else begin
          {state_next, wcnt_next} = enter_after_addr(wb, wm, waits_on);
        end
      end
      ST_ALH: begin
        {state_next, wcnt_next} = enter_after_addr(wb, wm, waits_on);
      end
      ST_SETUP: begin
        if (wcnt_reg <= 4'h1) begin
          state_next = ST_STRB;
          wcnt_next = wm;
        end else begin
          wcnt_next = wcnt_reg - 4'h1;
        end
      end
      ST_STRB: begin
        if (wcnt_reg == 4'h0) begin
          if (waits_on && we != 2'b00) begin
            state_next = ST_HOLD;
            wcnt_next = {2'b00, we};
          end else begin
            state_next = ST_DONE;
          end
        end else begin
          wcnt_next = wcnt_reg - 4'h1;
        end
      end
      ST_HOLD: begin
        if (wcnt_reg <= 4'h1) begin
          state_next = ST_DONE;
        end else begin
          wcnt_next = wcnt_reg - 4'h1;
        end
      end
      ST_DONE: begin
        if (last_byte) begin
          state_next = ST_IDLE;
        end else if (addr_mux_mode != `PMB_MUX_NONE) begin
          state_next = ST_ALL;
        end else begin
          {state_next, wcnt_next} = enter_after_addr(wb, wm, waits_on);
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Sequencer registers
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      wcnt_reg <= 4'h0;
      is_read_reg <= 1'b0;
      second_reg <= 1'b0;
      wbyte_low_reg <= `PMB_DATA_RST;
      wbyte_high_reg <= `PMB_DATA_RST;
      xfer_data_low <= `PMB_DATA_RST;
      xfer_data_high <= `PMB_DATA_RST;
      addr_reg <= `PMB_ADDR_RST;
      cycle_done_irq <= 1'b0;
    end else begin
      state_reg <= state_next;
      wcnt_reg <= wcnt_next;
      cycle_done_irq <= 1'b0;
      if (start_rd) begin
        is_read_reg <= 1'b1;
        second_reg <= 1'b0;
      end else if (take_wr) begin
        is_read_reg <= 1'b0;
        second_reg <= 1'b0;
        wbyte_low_reg <= fifo_data[7:0];
        wbyte_high_reg <= fifo_data[15:8];
      end
      if (state_reg == ST_STRB && wcnt_reg == 4'h0 && is_read_reg) begin
        if (second_reg) begin
          xfer_data_high <= port_data_in;
        end else begin
          xfer_data_low <= port_data_in;
        end
      end
      if (state_reg == ST_DONE) begin
        cycle_done_irq <= irq_enable && last_byte;
        second_reg <= !last_byte;
        if (last_byte) begin
          addr_reg <= addr_stepped;
        end
      end else if (addr_load && idle) begin
        addr_reg <= addr_load_value;
      end
    end
  end

  // ----------------------------------------
  // Pin outputs
  // ----------------------------------------
  wire strobe_on = (state_reg == ST_STRB);
  wire active = (state_next != ST_IDLE);
  wire [15:0] addr_eff = {
    (cs_func == `PMB_CSF_ADDR) ? addr_reg[15] : 1'b0,
    (cs_func == `PMB_CSF_BOTH) ? 1'b0 : addr_reg[14],
    addr_reg[13:0]};
  wire cs2_en = (cs_func == `PMB_CSF_CS2) || (cs_func == `PMB_CSF_BOTH);
  wire cs1_en = (cs_func == `PMB_CSF_BOTH);
  wire cs2_on = active && addr_reg[15];
  wire cs1_on = active && addr_reg[14];
  // Byte slot of the cycle about to run
  wire second_next = (state_reg == ST_DONE) ? !last_byte : second_reg;
  wire [7:0] wbyte = second_next ? wbyte_high_reg : wbyte_low_reg;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      port_data_out <= 8'h00;
      port_data_oe <= 1'b0;
      addr_pins <= 16'h0000;
      read_strobe_out <= 1'b0;
      write_strobe_out <= 1'b0;
      enable_strobe_out <= 1'b0;
      byte_enable_strobe <= 1'b0;
      addr_latch_low_strobe <= 1'b0;
      addr_latch_high_strobe <= 1'b0;
      chip_select_out <= 2'b00;
    end else begin
      addr_pins <= addr_eff;
      addr_latch_low_strobe <= (state_next == ST_ALL);
      addr_latch_high_strobe <= (state_next == ST_ALH);
      if (state_next == ST_ALL) begin
        port_data_out <= addr_eff[7:0];
        port_data_oe <= 1'b1;
      end else if (state_next == ST_ALH) begin
        port_data_out <= addr_eff[15:8];
        port_data_oe <= 1'b1;
      end else if (state_next != ST_IDLE && !is_read_next(start_rd, take_wr)) begin
        port_data_out <= take_wr ? fifo_data[7:0] : wbyte;
        port_data_oe <= 1'b1;
      end else begin
        port_data_oe <= 1'b0;
      end
      read_strobe_out <= 1'b0;
      write_strobe_out <= 1'b0;
      enable_strobe_out <= 1'b0;
      if (state_next == ST_STRB) begin
        if (enable_mode) begin
          enable_strobe_out <= 1'b1;
          read_strobe_out <= rd_flag(start_rd, take_wr);
        end else begin
          read_strobe_out <= rd_flag(start_rd, take_wr);
          write_strobe_out <= !rd_flag(start_rd, take_wr);
        end
      end else if (enable_mode && state_next != ST_IDLE) begin
        read_strobe_out <= rd_flag(start_rd, take_wr);
      end
      byte_enable_strobe <= wide_data_select && (state_next != ST_IDLE) && second_next;
      chip_select_out[0] <= cs1_en ? (cs1_on ^ !cs1_active_high) : 1'b0;
      chip_select_out[1] <= cs2_en ? (cs2_on ^ !cs2_active_high) : 1'b0;
    end
  end

  // Direction of the cycle about to run
  function rd_flag;
    input s_rd;
    input s_wr;
    begin
      rd_flag = s_rd ? 1'b1 : (s_wr ? 1'b0 : is_read_reg);
    end
  endfunction

  function is_read_next;
    input s_rd;
    input s_wr;
    begin
      is_read_next = rd_flag(s_rd, s_wr);
    end
  endfunction
endmodule
`default_nettype wire

// ===== test/pmb_mem_model.sv
// External byte memory on the parallel bus.
// Assumes active-high strobes, sampled on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module pmb_mem_model (
  // Clock
  input wire clk_sys,
  // Bus from the sequencer
  input wire [15:0] addr_pins,
  input wire read_strobe_out,
  input wire write_strobe_out,
  input wire byte_enable_strobe,
  input wire [7:0] port_data_out,
  input wire port_data_oe,
  // Data back and write tally
  output logic [7:0] port_data_in,
  output logic [7:0] wr_count
);
  // ----------
  // Storage
  // ----------
  logic [7:0] lo_mem [0:15];
  logic [7:0] hi_mem [0:15];
  logic [7:0] last_q = 8'h00;
  logic wr_q = 1'b0;
  wire [3:0] a = addr_pins[3:0];
  wire [7:0] rd_byte = byte_enable_strobe ? hi_mem[a] : lo_mem[a];
  initial begin
    wr_count = 8'h00;
  end
  // Released line shows the inverse of the last byte
  assign port_data_in = read_strobe_out ? rd_byte : ~last_q;
  always @(posedge clk_sys) begin
    wr_q <= write_strobe_out;
    if (read_strobe_out) last_q <= rd_byte;
    if (write_strobe_out && port_data_oe) begin
      if (byte_enable_strobe) hi_mem[a] <= port_data_out;
      else lo_mem[a] <= port_data_out;
    end
    if (write_strobe_out && !wr_q) wr_count <= wr_count + 8'h01;
  end
endmodule
`default_nettype wire

// ===== test/pmb_sequencer_checker.sv
// Port checks for the parallel master bus sequencer.
// Assumes one clock domain and binding to pmb_sequencer.
`timescale 1ns/1ps
`default_nettype none
module pmb_seq_checker (
  // Clock and reset
  input wire clk_sys,
  input wire sys_rst,
  // Configuration
  input wire [1:0] port_mode,
  input wire wide_data_select,
  input wire [1:0] addr_step_mode,
  input wire [7:0] port_wait_reg,
  input wire [1:0] addr_mux_mode,
  input wire [1:0] cs_func,
  input wire cs1_active_high,
  input wire irq_enable,
  // Status and pins
  input wire [15:0] addr_reg,
  input wire busy,
  input wire cycle_done_irq,
  input wire read_strobe_out,
  input wire write_strobe_out,
  input wire enable_strobe_out,
  input wire byte_enable_strobe,
  input wire [1:0] chip_select_out
);
  // ----------
  // Run lengths
  // ----------
  wire act = (port_mode == 2'b11) ? enable_strobe_out : (read_strobe_out | write_strobe_out);
  wire [5:0] wm = {2'b00, port_wait_reg[5:2]};
  wire [5:0] wbe = {4'h0, port_wait_reg[7:6]} + {4'h0, port_wait_reg[1:0]};
  wire [5:0] exp_busy = ((wm == 6'h00) ? 6'h01 : wm + wbe + 6'h01) + {4'h0, addr_mux_mode};
  reg [5:0] strb_len_reg;
  reg [5:0] busy_len_reg;
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      strb_len_reg <= 6'h00;
      busy_len_reg <= 6'h00;
    end else begin
      strb_len_reg <= act ? strb_len_reg + 6'h01 : 6'h00;
      busy_len_reg <= busy ? busy_len_reg + 6'h01 : 6'h00;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_irq_once;
    cycle_done_irq ##1 !cycle_done_irq;
  endsequence
  strobe_excl_a: assert property (port_mode == 2'b10
    |-> !(read_strobe_out && write_strobe_out))
    else $error("read and write strobes together");
  strobe_len_a: assert property ($fell(act) && !wide_data_select
    |-> strb_len_reg == wm + 6'h01)
    else $error("strobe length wrong");
  busy_len_a: assert property ($fell(busy) && !wide_data_select |-> busy_len_reg == exp_busy)
    else $error("busy length wrong");
  cs_idle_a: assert property (cs_func == 2'b10 && $past(cs_func) == 2'b10
    && $stable(cs1_active_high) && !busy && !$past(busy) && !$past(busy, 2)
    |-> chip_select_out[0] == !cs1_active_high)
    else $error("chip select active while idle");
  addr_hold_a: assert property (busy |=> $stable(addr_reg))
    else $error("address moved during transfer");
  step_up_a: assert property (cycle_done_irq && addr_step_mode == 2'b01 && cs_func == 2'b00
    |-> addr_reg == $past(addr_reg) + 16'h0001)
    else $error("address not stepped up");
  irq_off_a: assert property (!irq_enable && !$past(irq_enable) |-> !cycle_done_irq)
    else $error("event while disabled");
  irq_pulse_a: assert property (cycle_done_irq |-> s_irq_once)
    else $error("event longer than one cycle");
  irq_idle_a: assert property (cycle_done_irq |-> !busy && !$past(busy))
    else $error("event before busy cleared");
  be_wide_a: assert property (byte_enable_strobe |-> wide_data_select)
    else $error("byte enable in narrow mode");
endmodule
bind pmb_sequencer pmb_seq_checker u_chk (.*);
`default_nettype wire

// ===== test/pmb_sequencer_tb.sv
// Self-checking bench for the parallel master bus sequencer.
// Assumes the memory model on the bus and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module pmb_sequencer_tb;
  // ----------
  // Signals
  // ----------
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic port_enable = 1'b1;
  logic [1:0] port_mode = 2'b10;
  logic wide_data_select = 1'b0;
  logic [1:0] addr_step_mode = 2'b00;
  logic [7:0] port_wait_reg = 8'h00;
  logic [1:0] addr_mux_mode = 2'b00;
  logic [1:0] cs_func = 2'b00;
  logic cs1_active_high = 1'b1;
  logic cs2_active_high = 1'b1;
  logic irq_enable = 1'b0;
  logic addr_load = 1'b0;
  logic [15:0] addr_load_value = 16'h0000;
  logic data_low_read = 1'b0;
  logic data_low_write = 1'b0;
  logic [7:0] data_low_wdata = 8'h00;
  logic data_high_write = 1'b0;
  logic [7:0] data_high_wdata = 8'h00;
  wire write_ready, busy, cycle_done_irq, port_data_oe, read_strobe_out, write_strobe_out;
  wire enable_strobe_out, byte_enable_strobe, addr_latch_low_strobe, addr_latch_high_strobe;
  wire [7:0] xfer_data_low, xfer_data_high, port_data_out, port_data_in, wr_count;
  wire [15:0] addr_reg, addr_pins;
  wire [1:0] chip_select_out;
  logic [7:0] w [0:4] = '{8'h00, 8'h44, 8'hc7, 8'h3c, 8'hc3};
  int n_fail = 0;
  int checks_done = 0;
  int n_irq = 0;
  int n_all = 0;
  int n_alh = 0;
  pmb_sequencer dut (.*);
  pmb_mem_model u_mem (.*);
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    n_irq <= n_irq + cycle_done_irq;
    n_all <= n_all + addr_latch_low_strobe;
    n_alh <= n_alh + addr_latch_high_strobe;
  end
  // ----------
  // Tasks
  // ----------
  task automatic finish_test;
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cfg(input logic [1:0] md, input logic wd, input logic [1:0] st,
      input logic [7:0] wt, input logic [1:0] mx, input logic [1:0] cf);
    @(negedge clk_sys);
    port_mode = md;
    wide_data_select = wd;
    addr_step_mode = st;
    port_wait_reg = wt;
    addr_mux_mode = mx;
    cs_func = cf;
  endtask
  task automatic ld(input logic [15:0] a);
    @(negedge clk_sys);
    addr_load = 1'b1;
    addr_load_value = a;
    @(negedge clk_sys);
    addr_load = 1'b0;
  endtask
  // Request, then count busy cycles until the transfer ends
  task automatic xfer(input logic wr, input logic [7:0] lo, input logic [7:0] hi, output int n);
    int i;
    n = 0;
    @(negedge clk_sys);
    data_low_read = !wr;
    data_low_write = wr;
    data_low_wdata = lo;
    data_high_wdata = hi;
    @(negedge clk_sys);
    data_low_read = 1'b0;
    data_low_write = 1'b0;
    for (i = 0; i < 80; i++) begin
      if (busy === 1'b1) n++;
      else if (n > 0 || i > 4) break;
      @(negedge clk_sys);
    end
    if (i == 80) begin
      n_fail++;
      finish_test();
    end
    repeat (2) @(negedge clk_sys);
  endtask
  // ----------
  // Scenarios
  // ----------
  initial begin
    int n;
    int k;
    int m;
    logic [7:0] m8;
    repeat (12) @(negedge clk_sys);
    sys_rst = 1'b0;
    `CHK(busy, 1'b0)
    `CHK(write_ready, 1'b1)
    `CHK(addr_reg, 16'h0000)
    irq_enable = 1'b1;
    cfg(2'b10, 1'b0, 2'b01, 8'h00, 2'b00, 2'b00);
    ld(16'h0004);
    xfer(1'b1, 8'ha5, 8'h00, n); `CHK(n, 1)
    xfer(1'b1, 8'h5a, 8'h00, n); `CHK(addr_reg, 16'h0006)
    `CHK(wr_count, 8'h02)
    ld(16'h0004);
    xfer(1'b0, 8'h00, 8'h00, n); `CHK(xfer_data_low, 8'ha5)
    xfer(1'b0, 8'h00, 8'h00, n); `CHK(xfer_data_low, 8'h5a)
    cfg(2'b10, 1'b0, 2'b10, 8'h00, 2'b00, 2'b00);
    xfer(1'b0, 8'h00, 8'h00, n); `CHK(addr_reg, 16'h0005)
    cfg(2'b10, 1'b0, 2'b00, 8'h00, 2'b00, 2'b00);
    xfer(1'b0, 8'h00, 8'h00, n); `CHK(addr_reg, 16'h0005)
    cfg(2'b10, 1'b1, 2'b01, 8'h00, 2'b00, 2'b00);
    ld(16'h0008);
    xfer(1'b1, 8'h3c, 8'hc3, n); `CHK(wr_count, 8'h04)
    `CHK(addr_reg, 16'h0009)
    ld(16'h0008);
    xfer(1'b0, 8'h00, 8'h00, n); `CHK(xfer_data_low, 8'h3c)
    `CHK(xfer_data_high, 8'hc3)
    for (k = 0; k < 5; k++) begin
      cfg(k[0] ? 2'b11 : 2'b10, 1'b0, 2'b00, w[k], 2'b00, 2'b00);
      xfer(1'b0, 8'h00, 8'h00, n);
      `CHK(n, (w[k][5:2] == 4'h0) ? 1 : w[k][7:6] + w[k][5:2] + w[k][1:0] + 1)
    end
    for (k = 1; k < 3; k++) begin
      cfg(2'b10, 1'b0, 2'b00, 8'h00, k[1:0], 2'b00);
      xfer(1'b0, 8'h00, 8'h00, n); `CHK(n, k + 1)
    end
    `CHK(n_all, 2)
    `CHK(n_alh, 1)
    cs1_active_high = 1'b0;
    cfg(2'b10, 1'b0, 2'b01, 8'h00, 2'b00, 2'b10);
    ld(16'hffff);
    xfer(1'b0, 8'h00, 8'h00, n); `CHK(addr_reg, 16'hc000)
    `CHK(chip_select_out, 2'b01)
    cfg(2'b10, 1'b0, 2'b01, 8'h00, 2'b00, 2'b00);
    ld(16'hffff);
    xfer(1'b0, 8'h00, 8'h00, n); `CHK(addr_reg, 16'h0000)
    m = n_irq;
    xfer(1'b0, 8'h00, 8'h00, n); `CHK(n_irq, m + 1)
    irq_enable = 1'b0;
    xfer(1'b0, 8'h00, 8'h00, n); `CHK(n_irq, m + 1)
    irq_enable = 1'b1;
    cfg(2'b10, 1'b0, 2'b01, 8'h3c, 2'b00, 2'b00);
    ld(16'h0000);
    m = n_irq;
    // Second read request lands while the first is still busy
    for (k = 0; k < 6; k++) begin
      @(negedge clk_sys);
      data_low_read = (k == 0 || k == 4);
    end
    for (k = 0; k < 40 && busy !== 1'b0; k++) @(negedge clk_sys);
    if (k == 40) n_fail++;
    repeat (2) @(negedge clk_sys);
    `CHK(addr_reg, 16'h0001)
    `CHK(n_irq, m + 1)
    port_enable = 1'b0;
    m8 = wr_count;
    xfer(1'b0, 8'h00, 8'h00, n); `CHK(n, 0)
    xfer(1'b1, 8'h77, 8'h00, n); `CHK(n, 0)
    port_enable = 1'b1;
    cfg(2'b10, 1'b0, 2'b01, 8'hff, 2'b00, 2'b00);
    // Seventeen writes: one drains at once, sixteen fill the queue
    for (k = 0; k < 18; k++) begin
      @(negedge clk_sys);
      data_low_write = (k < 17);
      data_low_wdata = k[7:0];
    end
    `CHK(write_ready, 1'b0)
    for (k = 0; k < 600 && wr_count !== m8 + 8'h11; k++) @(negedge clk_sys);
    `CHK(wr_count, m8 + 8'h11)
    finish_test();
  end
endmodule
`default_nettype wire
